// ==== src/svqf_defines.vh ====
// Constants for the switch VLAN, forwarding and QoS engine.
`ifndef SVQF_DEFINES_VH
`define SVQF_DEFINES_VH
`define CR1_SPLIT       0
`define CR1_TAG_DEL     1
`define CR1_TAG_INS     2
`define CR1_PPRI        4:3
`define CR1_DOT1P       5
`define CR1_DSCP        6
`define CR2_CEIL        3
`define GFC_UNK_FILTER  7
`define VT_VID          11:0
`define VT_FID          15:12
`define VT_MEMBERS      18:16
`define VT_VALID        19
`define ST_MAC          47:0
`define ST_PORTS        50:48
`define ST_USE_FID      51
`define ST_VALID        52
`define ST_FID          56:53
`define DT_FID          51:48
`define DT_PORT         53:52
`define DT_VALID        54
`define DT_STAMP        62:55
`define TAG_PCP         15:13
`define TAG_VID         11:0
`define MAC_GROUP_BIT   40
`define NULL_VID        12'h000
`define CLK_HZ          32'h02fa_f080
`define RATE_UNIT_BPS   32'h0000_fa00
`define RATE_SCALE      ((`CLK_HZ * 32'h0000_0008) / `RATE_UNIT_BPS)
`define RATE_10M_UNITS  11'h09c
`define IFG_BYTES       11'h00c
`define PREAMBLE_BYTES  11'h008
`define BUCKET_CAP      27'h0c3_5000
`define QUEUE_LIMIT     8'h40
`endif

// ==== src/svqf_engine.v ====
// Forwarding, classification and rate control engine of a three-port switch.
//
// Functional notes
// - Sixteen-entry VLAN table maps 12-bit VLAN id to 4-bit filter group.
// - Untagged or null-id frames use the ingress port default VLAN id.
// - VLAN mode: unknown VLAN id drops the frame and skips learning.
// - Static and dynamic miss, or mismatched group and dynamic miss: flood members.
// - Dynamic hit after static miss or group mismatch: send to learned port.
// - Static hit with group flag clear or group match: send to static ports.
// - Source plus group: add to dynamic table on miss, refresh stamp on hit.
// - Split bit set gives four egress queues, queue 3 highest.
// - Port priority field gives the priority of frames that neither 802.1p nor DiffServ classifies.
// - 802.1p enable maps the tag priority through the priority map.
// - Tag insertion adds ingress default tag to untagged frames only.
// - Tag removal strips tags from tagged frames only.
// - Any inserted or removed tag forces frame check recompute.
// - Priority ceiling lowers tag priority to the default tag priority.
// - DiffServ code point from upper ToS bits selects 2 bits of map.
// - Receive and transmit rate limits per priority per port.
// - On 10 Mbps ports limits above 10 Mbps mean unlimited.
// - Rate length counts DA through FCS plus optional gap or preamble.
// - Ingress counts only the selected class and drops while over rate.
// - Egress leaky bucket per queue stretches the gap to hold rate.
// - Exhausted queue memory drops frames and raises flow control on enabled ports.
// - Global bit chooses filtering of unknown unicast frames.
`include "svqf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module svqf_engine (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // Parsed frame descriptor
  input  wire         frm_valid,
  input  wire [1:0]   frm_port,
  input  wire         frm_tagged,
  input  wire [11:0]  frm_vid,
  input  wire [2:0]   frm_pcp,
  input  wire         frm_ip,
  input  wire [7:0]   frm_tos,
  input  wire [47:0]  frm_da,
  input  wire [47:0]  frm_sa,
  input  wire [10:0]  frm_len,
  // Table writes
  input  wire         vlan_wr,
  input  wire [3:0]   vlan_wr_idx,
  input  wire [19:0]  vlan_wr_data,
  input  wire         static_wr,
  input  wire [2:0]   static_wr_idx,
  input  wire [56:0]  static_wr_data,
  // Port configuration
  input  wire [7:0]   port1_control_one,
  input  wire [7:0]   port2_control_one,
  input  wire [7:0]   hostport_control_one,
  input  wire [7:0]   port1_control_two,
  input  wire [7:0]   port2_control_two,
  input  wire [7:0]   hostport_control_two,
  input  wire [15:0]  port1_default_tag_config,
  input  wire [15:0]  port2_default_tag_config,
  input  wire [15:0]  hostport_default_tag_config,
  input  wire [2:0]   port_is_10m,
  input  wire [2:0]   flow_ctrl_en,
  input  wire [5:0]   ingress_rate_class,
  // Global configuration
  input  wire         vlan_enable,
  input  wire [15:0]  priority_map_config,
  input  wire [7:0]   global_forward_config,
  input  wire [127:0] dscp_priority_map,
  input  wire [1:0]   rate_len_mode,
  input  wire [131:0] rx_rate_limit,
  input  wire [131:0] tx_rate_limit,
  // Transmit completions
  input  wire         tx_done,
  input  wire [1:0]   tx_port,
  input  wire [1:0]   tx_queue,
  input  wire [10:0]  tx_len,
  // Forwarding decision
  output reg          fwd_valid,
  output reg          fwd_drop,
  output reg  [2:0]   fwd_ports,
  output reg  [5:0]   fwd_queue,
  output reg  [2:0]   fwd_pcp,
  output reg  [15:0]  fwd_tag,
  output reg  [2:0]   fwd_tag_ins,
  output reg  [2:0]   fwd_tag_del,
  output reg  [2:0]   fwd_fcs_redo,
  // Traffic management
  output reg  [2:0]   flow_pause,
  output reg  [11:0]  tx_hold
);

////////////////////////////////////////////////////////////////////////////////
wire [7:0]  cr1  [0:2];
wire [7:0]  cr2  [0:2];
wire [15:0] dtag [0:2];
assign cr1[0]  = port1_control_one;
assign cr1[1]  = port2_control_one;
assign cr1[2]  = hostport_control_one;
assign cr2[0]  = port1_control_two;
assign cr2[1]  = port2_control_two;
assign cr2[2]  = hostport_control_two;
assign dtag[0] = port1_default_tag_config;
assign dtag[1] = port2_default_tag_config;
assign dtag[2] = hostport_default_tag_config;

reg [19:0] vlan_tab [0:15];
reg [56:0] stat_tab [0:7];
reg [62:0] dyn_tab  [0:7];
reg [26:0] rx_lvl   [0:11];
reg [26:0] tx_lvl   [0:11];
reg [7:0]  occ      [0:2];
reg [15:0] age_clk;
reg [2:0]  learn_rr;

////////////////////////////////////////////////////////////////////////////////
// A zero setting also means no limit.
function rate_off;
  input [10:0] rate;
  input        slow;
  begin
    rate_off = (rate == 11'h000) || (slow && (rate > `RATE_10M_UNITS));
  end
endfunction

// Cost in bucket units: one unit is one cycle's worth of the rate step.
function [26:0] frame_cost;
  input [10:0] len;
  input [1:0]  mode;
  reg   [31:0] t;
  begin
    t = {21'h00_0000, len};
    if (mode[0]) t = t + {21'h00_0000, `IFG_BYTES};
    if (mode[1]) t = t + {21'h00_0000, `PREAMBLE_BYTES};
    t = t * `RATE_SCALE;
    frame_cost = t[26:0];
  end
endfunction

// Levels are two's complement; a negative level means over rate.
function [26:0] bucket_next;
  input [26:0] lvl;
  input [10:0] rate;
  input        off;
  input        charge;
  input [26:0] cost;
  reg   [26:0] l;
  begin
    l = lvl + {16'h0000, rate};
    if (!lvl[26] && (l > `BUCKET_CAP)) l = `BUCKET_CAP;
    if (charge) l = l - cost;
    bucket_next = off ? `BUCKET_CAP : l;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg [11:0] eff_vid;
reg        v_hit;
reg [19:0] v_ent;
reg        s_hit;
reg [56:0] s_ent;
reg        s_use;
reg        d_hit;
reg [1:0]  d_port;
reg        sa_hit;
reg [2:0]  sa_idx;
reg        free_found;
reg [2:0]  free_idx;
reg [3:0]  filter_group_id;
reg [2:0]  ports;
reg [2:0]  pcp_c;
reg [1:0]  prio;
reg [3:0]  ri;
reg        flooded;
reg        counted;
reg        over;
reg        full;
reg        any_full;
reg        vdrop;
reg        drop;
reg [2:0]  ins;
reg [2:0]  del;
reg [5:0]  qsel;
integer    i;

always @* begin
  eff_vid = (!frm_tagged || (frm_vid == `NULL_VID)) ? dtag[frm_port][`TAG_VID] : frm_vid;
  v_hit = 1'b0;
  v_ent = 20'h0_0000;
  for (i = 0; i < 16; i = i + 1) begin
    if (vlan_tab[i][`VT_VALID] && (vlan_tab[i][`VT_VID] == eff_vid)) begin
      v_hit = 1'b1;
      v_ent = vlan_tab[i];
    end
  end
  // Outside VLAN mode everything shares filter group zero and floods to all.
  filter_group_id   = vlan_enable ? v_ent[`VT_FID] : 4'h0;
  vdrop = vlan_enable && !v_hit;
  s_hit = 1'b0;
  s_ent = 57'h0;
  d_hit = 1'b0;
  d_port = 2'b00;
  sa_hit = 1'b0;
  sa_idx = 3'b000;
  free_found = 1'b0;
  free_idx = 3'b000;
  for (i = 7; i >= 0; i = i - 1) begin
    if (stat_tab[i][`ST_VALID] && (stat_tab[i][`ST_MAC] == frm_da)) begin
      s_hit = 1'b1;
      s_ent = stat_tab[i];
    end
    if (dyn_tab[i][`DT_VALID] && (dyn_tab[i][47:0] == frm_da) && (dyn_tab[i][`DT_FID] == filter_group_id)) begin
      d_hit = 1'b1;
      d_port = dyn_tab[i][`DT_PORT];
    end
    if (dyn_tab[i][`DT_VALID] && (dyn_tab[i][47:0] == frm_sa) && (dyn_tab[i][`DT_FID] == filter_group_id)) begin
      sa_hit = 1'b1;
      sa_idx = i[2:0];
    end
    if (!dyn_tab[i][`DT_VALID]) begin
      free_found = 1'b1;
      free_idx = i[2:0];
    end
  end
  s_use = s_hit && (!s_ent[`ST_USE_FID] || (s_ent[`ST_FID] == filter_group_id));
  flooded = !s_use && !d_hit;
  if (s_use)
    ports = s_ent[`ST_PORTS];
  else if (d_hit)
    ports = 3'b001 << d_port;
  else if (vlan_enable)
    ports = v_ent[`VT_MEMBERS];
  else
    ports = 3'b111;
  if (flooded && !frm_da[`MAC_GROUP_BIT] && global_forward_config[`GFC_UNK_FILTER])
    ports = 3'b000;
  ports = ports & ~(3'b001 << frm_port);
  // Priority: 802.1p first, then DiffServ, then the port level.
  if (cr2[frm_port][`CR2_CEIL] && (frm_pcp > dtag[frm_port][`TAG_PCP]))
    pcp_c = dtag[frm_port][`TAG_PCP];
  else
    pcp_c = frm_pcp;
  if (cr1[frm_port][`CR1_DOT1P] && frm_tagged)
    prio = priority_map_config[{pcp_c, 1'b0} +: 2];
  else if (cr1[frm_port][`CR1_DSCP] && frm_ip)
    prio = dscp_priority_map[{frm_tos[7:2], 1'b0} +: 2];
  else
    prio = cr1[frm_port][`CR1_PPRI];
  ri = {frm_port, prio};
  case (ingress_rate_class[{frm_port, 1'b0} +: 2])
    2'b00:   counted = 1'b1;
    2'b01:   counted = frm_da[`MAC_GROUP_BIT] && !(&frm_da);
    2'b10:   counted = &frm_da;
    default: counted = flooded && !frm_da[`MAC_GROUP_BIT];
  endcase
  over = counted && rx_lvl[ri][26] && !rate_off(rx_rate_limit[ri * 11 +: 11], port_is_10m[frm_port]);
  full = 1'b0;
  any_full = 1'b0;
  for (i = 0; i < 3; i = i + 1) begin
    if (occ[i] >= `QUEUE_LIMIT) begin
      any_full = 1'b1;
      if (ports[i]) full = 1'b1;
    end
    ins[i] = cr1[i][`CR1_TAG_INS] && !frm_tagged;
    del[i] = cr1[i][`CR1_TAG_DEL] && frm_tagged;
    qsel[i * 2 +: 2] = cr1[i][`CR1_SPLIT] ? prio : 2'b00;
  end
  drop = vdrop || over || full || (ports == 3'b000);
end

////////////////////////////////////////////////////////////////////////////////
integer j;

always @(posedge core_clk or negedge rst_n) begin
  if (!rst_n) begin
    fwd_valid    <= 1'b0;
    fwd_drop     <= 1'b0;
    fwd_ports    <= 3'b000;
    fwd_queue    <= 6'h00;
    fwd_pcp      <= 3'b000;
    fwd_tag      <= 16'h0000;
    fwd_tag_ins  <= 3'b000;
    fwd_tag_del  <= 3'b000;
    fwd_fcs_redo <= 3'b000;
    flow_pause   <= 3'b000;
    tx_hold      <= 12'h000;
    age_clk      <= 16'h0000;
    learn_rr     <= 3'b000;
    for (j = 0; j < 16; j = j + 1) vlan_tab[j] <= 20'h0_0000;
    for (j = 0; j < 8; j = j + 1) begin
      stat_tab[j] <= 57'h0;
      dyn_tab[j]  <= 63'h0;
    end
    for (j = 0; j < 12; j = j + 1) begin
      rx_lvl[j] <= `BUCKET_CAP;
      tx_lvl[j] <= `BUCKET_CAP;
    end
    for (j = 0; j < 3; j = j + 1) occ[j] <= 8'h00;
  end else begin
    age_clk <= age_clk + 16'h0001;
    if (vlan_wr) vlan_tab[vlan_wr_idx] <= vlan_wr_data;
    if (static_wr) stat_tab[static_wr_idx] <= static_wr_data;
    fwd_valid    <= frm_valid;
    fwd_drop     <= frm_valid && drop;
    fwd_ports    <= (frm_valid && !drop) ? ports : 3'b000;
    fwd_queue    <= qsel;
    fwd_pcp      <= pcp_c;
    fwd_tag      <= dtag[frm_port];
    fwd_tag_ins  <= (frm_valid && !drop) ? (ports & ins) : 3'b000;
    fwd_tag_del  <= (frm_valid && !drop) ? (ports & del) : 3'b000;
    fwd_fcs_redo <= (frm_valid && !drop) ? (ports & (ins | del)) : 3'b000;
    // Source learning; a full table recycles entries round robin.
    if (frm_valid && !vdrop && !frm_sa[`MAC_GROUP_BIT]) begin
      if (sa_hit)
        dyn_tab[sa_idx][`DT_STAMP] <= age_clk[15:8];
      else if (free_found)
        dyn_tab[free_idx] <= {age_clk[15:8], 1'b1, frm_port, filter_group_id, frm_sa};
      else begin
        dyn_tab[learn_rr] <= {age_clk[15:8], 1'b1, frm_port, filter_group_id, frm_sa};
        learn_rr <= learn_rr + 3'b001;
      end
    end
    for (j = 0; j < 12; j = j + 1) begin
      rx_lvl[j] <= bucket_next(rx_lvl[j], rx_rate_limit[j * 11 +: 11],
                               rate_off(rx_rate_limit[j * 11 +: 11], port_is_10m[j / 4]),
                               frm_valid && !drop && counted && (ri == j),
                               frame_cost(frm_len, rate_len_mode));
      tx_lvl[j] <= bucket_next(tx_lvl[j], tx_rate_limit[j * 11 +: 11],
                               rate_off(tx_rate_limit[j * 11 +: 11], port_is_10m[j / 4]),
                               tx_done && ({tx_port, tx_queue} == j),
                               frame_cost(tx_len, rate_len_mode));
      tx_hold[j] <= tx_lvl[j][26] && !rate_off(tx_rate_limit[j * 11 +: 11], port_is_10m[j / 4]);
    end
    for (j = 0; j < 3; j = j + 1) begin
      occ[j] <= occ[j] + {7'h00, frm_valid && !drop && ports[j]}
                       - {7'h00, tx_done && (tx_port == j) && (occ[j] != 8'h00)};
      flow_pause[j] <= flow_ctrl_en[j] && any_full;
    end
  end
end

endmodule // svqf_engine
`default_nettype wire

// ==== test/svqf_engine_assertions.sv ====
// Checker for the forwarding decision and pause outputs of the engine.
`timescale 1ns/1ps
`default_nettype none
module svqf_engine_chk (
  // Clock, reset and requests
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        frm_valid,
  input wire logic [1:0]  frm_port,
  input wire logic        frm_tagged,
  input wire logic [7:0]  port1_control_one,
  input wire logic [7:0]  port1_control_two,
  input wire logic [15:0] port1_default_tag_config,
  input wire logic [2:0]  flow_ctrl_en,
  // Decision and traffic outputs
  input wire logic        fwd_valid,
  input wire logic        fwd_drop,
  input wire logic [2:0]  fwd_ports,
  input wire logic [5:0]  fwd_queue,
  input wire logic [2:0]  fwd_pcp,
  input wire logic [2:0]  fwd_tag_ins,
  input wire logic [2:0]  fwd_tag_del,
  input wire logic [2:0]  fwd_fcs_redo,
  input wire logic [2:0]  flow_pause
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; frm_valid; endsequence
  sequence s_tag; frm_valid && frm_tagged; endsequence
  sequence s_untag; frm_valid && !frm_tagged; endsequence
  property p_ans; s_req |=> fwd_valid; endproperty
  a_ans: assert property (p_ans) else $error("decision missing one cycle after request");
  property p_drop; fwd_valid && fwd_drop |-> fwd_ports == 3'b000; endproperty
  a_drop: assert property (p_drop) else $error("dropped frame still has egress ports");
  property p_own; s_req ##0 frm_port == 2'd0 |=> !fwd_ports[0]; endproperty
  a_own: assert property (p_own) else $error("frame sent back to its ingress port");
  property p_ins; s_tag |=> fwd_tag_ins == 3'b000; endproperty
  a_ins: assert property (p_ins) else $error("tag inserted into tagged frame");
  property p_del; s_untag |=> fwd_tag_del == 3'b000; endproperty
  a_del: assert property (p_del) else $error("tag removed from untagged frame");
  property p_fcs; fwd_valid |-> fwd_fcs_redo == (fwd_tag_ins | fwd_tag_del); endproperty
  a_fcs: assert property (p_fcs) else $error("check sequence redo flag wrong");
  property p_unsplit; s_req ##0 !port1_control_one[0] |=> !fwd_ports[0] || fwd_queue[1:0] == 2'b00; endproperty
  a_unsplit: assert property (p_unsplit) else $error("unsplit port used nonzero queue");
  property p_ceil;
    s_tag ##0 (frm_port == 2'd0 && port1_control_two[3]) |=> fwd_pcp <= $past(port1_default_tag_config[15:13]);
  endproperty
  a_ceil: assert property (p_ceil) else $error("priority above ceiling");
  property p_pause; (flow_pause & ~$past(flow_ctrl_en)) == 3'b000; endproperty
  a_pause: assert property (p_pause) else $error("pause on port without flow control");
endmodule // svqf_engine_chk
bind svqf_engine svqf_engine_chk u_svqf_engine_chk (.core_clk, .rst_n, .frm_valid, .frm_port, .frm_tagged,
  .port1_control_one, .port1_control_two, .port1_default_tag_config, .flow_ctrl_en, .fwd_valid, .fwd_drop,
  .fwd_ports, .fwd_queue, .fwd_pcp, .fwd_tag_ins, .fwd_tag_del, .fwd_fcs_redo, .flow_pause);
`default_nettype wire

// ==== test/svqf_port_model.sv ====
// Egress side model that retires forwarded frames after a short or long delay.
`timescale 1ns/1ps
`default_nettype none
module svqf_port_model (
  // Clock, reset and pace
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  // Decision side
  input  wire logic        frm_valid,
  input  wire logic [10:0] frm_len,
  input  wire logic        fwd_valid,
  input  wire logic        fwd_drop,
  input  wire logic [2:0]  fwd_ports,
  input  wire logic [5:0]  fwd_queue,
  // Completions
  output logic             tx_done,
  output logic [1:0]       tx_port,
  output logic [1:0]       tx_queue,
  output logic [10:0]      tx_len
);
  logic [10:0] len_q;
  logic [10:0] plen;
  logic [1:0]  port_q;
  logic [1:0]  queue_q;
  logic [5:0]  wait_cnt;
  // Only one frame is in flight; others stay queued, which lets occupancy build up.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done <= 1'b0;
      tx_port <= 2'd0;
      tx_queue <= 2'd0;
      tx_len <= 11'd0;
      wait_cnt <= 6'd0;
    end else begin
      tx_done <= wait_cnt == 6'd1;
      tx_port <= (wait_cnt == 6'd1) ? port_q : ~tx_port;
      tx_queue <= (wait_cnt == 6'd1) ? queue_q : ~tx_queue;
      tx_len <= (wait_cnt == 6'd1) ? plen : ~tx_len;
      if (frm_valid)
        len_q <= frm_len;
      if (fwd_valid && !fwd_drop && fwd_ports != 3'b000 && wait_cnt == 6'd0) begin
        wait_cnt <= slow ? 6'd40 : 6'd2;
        port_q <= fwd_ports[0] ? 2'd0 : (fwd_ports[1] ? 2'd1 : 2'd2);
        queue_q <= fwd_ports[0] ? fwd_queue[1:0] : (fwd_ports[1] ? fwd_queue[3:2] : fwd_queue[5:4]);
        plen <= len_q;
      end else if (wait_cnt != 6'd0)
        wait_cnt <= wait_cnt - 6'd1;
    end
  end
endmodule // svqf_port_model
`default_nettype wire

// ==== test/tb_svqf_engine.sv ====
// Self-checking bench for the forwarding engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_svqf_engine;
  logic core_clk = 0, rst_n = 0, frm_valid = 0, frm_tagged = 0, frm_ip = 0, vlan_wr = 0, static_wr = 0;
  logic vlan_enable = 0, slow = 0, tx_done, fwd_valid, fwd_drop;
  logic [1:0] frm_port = 0, rate_len_mode = 0, tx_port, tx_queue, exp_q;
  logic [2:0] frm_pcp = 0, port_is_10m = 0, flow_ctrl_en = 3'h7, static_wr_idx = 0;
  logic [2:0] fwd_ports, fwd_pcp, fwd_tag_ins, fwd_tag_del, fwd_fcs_redo, flow_pause;
  logic [7:0] frm_tos = 0, port1_control_one = 0, port2_control_one = 0, hostport_control_one = 0;
  logic [7:0] port1_control_two = 0, port2_control_two = 0, hostport_control_two = 0, global_forward_config = 0;
  logic [10:0] frm_len = 11'h040, tx_len;
  logic [11:0] frm_vid = 0, tx_hold;
  logic [15:0] port1_default_tag_config = 16'h4000, port2_default_tag_config = 0, priority_map_config = 0, fwd_tag;
  logic [15:0] hostport_default_tag_config = 16'h0123;
  logic [3:0] vlan_wr_idx = 0;
  logic [19:0] vlan_wr_data = 0;
  logic [56:0] static_wr_data = 0;
  logic [47:0] frm_da = 0, frm_sa = 0, mac_c, mac_b;
  logic [5:0] ingress_rate_class = 0, fwd_queue;
  logic [127:0] dscp_priority_map = 0;
  logic [131:0] rx_rate_limit = 0, tx_rate_limit = 0;
  integer num_errors = 0, tests_run = 0, seed = 32'hf7e116dd, cyc = 0, i, m, r;
  svqf_engine u_svqf_engine (.core_clk, .rst_n, .frm_valid, .frm_port, .frm_tagged, .frm_vid, .frm_pcp, .frm_ip,
    .frm_tos, .frm_da, .frm_sa, .frm_len, .vlan_wr, .vlan_wr_idx, .vlan_wr_data, .static_wr, .static_wr_idx,
    .static_wr_data, .port1_control_one, .port2_control_one, .hostport_control_one, .port1_control_two,
    .port2_control_two, .hostport_control_two, .port1_default_tag_config, .port2_default_tag_config,
    .hostport_default_tag_config, .port_is_10m, .flow_ctrl_en, .ingress_rate_class, .vlan_enable,
    .priority_map_config, .global_forward_config, .dscp_priority_map, .rate_len_mode, .rx_rate_limit,
    .tx_rate_limit, .tx_done, .tx_port, .tx_queue, .tx_len, .fwd_valid, .fwd_drop, .fwd_ports, .fwd_queue,
    .fwd_pcp, .fwd_tag, .fwd_tag_ins, .fwd_tag_del, .fwd_fcs_redo, .flow_pause, .tx_hold);
  svqf_port_model u_svqf_port_model (.core_clk, .rst_n, .slow, .frm_valid, .frm_len, .fwd_valid, .fwd_drop,
    .fwd_ports, .fwd_queue, .tx_done, .tx_port, .tx_queue, .tx_len);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic [47:0] rnd_uc;
    rnd_uc = 48'({$random(seed), $random(seed)});
    rnd_uc[40] = 1'b0;
  endfunction
  function automatic [2:0] others(input [1:0] p);
    others = 3'b111 & ~(3'b001 << p);
  endfunction
  task do_reset;
    @(posedge core_clk) #1 rst_n = 0;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1;
  endtask
  // Fields stay put after the pulse so the decision is read one cycle later.
  task send(input [1:0] p, input t, input [11:0] v, input [2:0] pc, input [47:0] da);
    @(posedge core_clk) #1 frm_valid = 1;
    {frm_port, frm_tagged, frm_vid, frm_pcp, frm_da} = {p, t, v, pc, da};
    @(posedge core_clk) #1 frm_valid = 0;
  endtask
  task wr_tab(input vt, input [3:0] idx, input [56:0] d);
    @(posedge core_clk) #1 {vlan_wr, static_wr} = {vt, !vt};
    {vlan_wr_idx, static_wr_idx, vlan_wr_data, static_wr_data} = {idx, idx[2:0], d[19:0], d};
    @(posedge core_clk) #1 {vlan_wr, static_wr} = 2'b00;
  endtask
  task rate_run(input s10, input [10:0] lim, input [10:0] len, input [1:0] md, input exp3);
    do_reset;
    {port_is_10m, rx_rate_limit, port1_control_one, frm_len, rate_len_mode} = {2'b00, s10, 121'h0, lim, 8'h00, len, md};
    for (m = 0; m < 3; m++)
      send(2'd0, 0, 0, 0, rnd_uc());
    `CHK("rate drop", exp3, fwd_drop)
  endtask
  initial begin
    do_reset;
    mac_c = rnd_uc();
    mac_b = rnd_uc();
    frm_sa = mac_c;
    send(2'd1, 0, 0, 0, rnd_uc());
    `CHK("flood", others(1), fwd_ports)
    frm_sa = rnd_uc();
    send(2'd0, 0, 0, 0, mac_c);
    `CHK("learned", 3'b010, fwd_ports)
    global_forward_config = 8'h80;
    send(2'd2, 0, 0, 0, rnd_uc());
    `CHK("unknown filtered", 2'b10, {fwd_drop, |fwd_ports})
    global_forward_config = 8'h00;
    wr_tab(0, 4'd0, {4'h0, 2'b10, 3'b100, mac_b});
    send(2'd0, 0, 0, 0, mac_b);
    `CHK("static", 3'b100, fwd_ports)
    wr_tab(0, 4'd1, {4'h9, 2'b11, 3'b001, mac_b ^ 48'h1});
    wr_tab(1, 4'd5, {37'h0, 1'b1, 3'b011, 4'h3, 12'h123});
    vlan_enable = 1;
    send(2'd2, 1, 12'h456, 0, rnd_uc());
    `CHK("unknown vlan", 1'b1, fwd_drop)
    for (i = 0; i < 2; i++) begin
      send(2'd2, i[0], 12'h000, 0, mac_b ^ 48'h1);
      `CHK("default vlan flood", 3'b011, fwd_ports)
    end
    vlan_enable = 0;
    {port2_control_one, priority_map_config} = {8'h05, 16'($random(seed))};
    dscp_priority_map = {4{$random(seed)}};
    for (i = 0; i < 16; i++) begin
      {m, r, slow} = {i % 4, $random(seed), i[0]};
      port1_control_one = (m == 0) ? {3'b000, r[1:0], 3'b000} : (m == 2 ? 8'h40 : 8'h20);
      {port1_control_two, frm_ip, frm_tos} = {(m == 3) ? 8'h08 : 8'h00, m == 2, r[7:0]};
      exp_q = (m == 0) ? r[1:0] : (m == 2 ? dscp_priority_map[r[7:2] * 2 +: 2] : priority_map_config[r[10:8] * 2 +: 2]);
      if (m == 3) exp_q = priority_map_config[5:4];
      send(2'd0, m[0], 0, (m == 3) ? 3'h7 : r[10:8], mac_c);
      `CHK("queue", {3'b010, exp_q}, {fwd_ports, fwd_queue[3:2]})
      `CHK("insert", {!m[0], !m[0]}, {fwd_tag_ins[1], fwd_fcs_redo[1]})
      `CHK("default tag", port1_default_tag_config, fwd_tag)
      if (m == 3) `CHK("ceiling", 3'h2, fwd_pcp)
    end
    {port2_control_one, slow} = {8'h02, 1'b0};
    send(2'd0, 1, 0, 0, mac_c);
    `CHK("removed", 2'b11, {fwd_tag_del[1], fwd_fcs_redo[1]})
    `CHK("unsplit", 2'b00, fwd_queue[3:2])
    rate_run(1, 11'h7ff, 11'd1500, 2'b00, 0);
    rate_run(0, 11'h001, 11'd1020, 2'b00, 0);
    rate_run(0, 11'h001, 11'd1020, 2'b01, 1);
    rate_run(0, 11'h001, 11'd1020, 2'b10, 1);
    rate_run(0, 11'h001, 11'd1500, 2'b00, 1);
    // Flooded frames from the second port are retired only on the first port, so the host queue fills.
    tx_rate_limit[10:0] = 11'h001;
    for (m = 0; m < 2; m++) begin
      send(2'd1, 0, 0, 0, rnd_uc());
      #120;
      `CHK("egress hold", m[0], tx_hold[0])
    end
    flow_ctrl_en = 3'b101;
    for (m = 0; m < 70; m++)
      send(2'd1, 0, 0, 0, rnd_uc());
    `CHK("queue full", 5'b10101, {fwd_drop, |fwd_ports, flow_pause})
    wrap_up;
  end
endmodule // tb_svqf_engine
`default_nettype wire
